// [logic/atd_pkg.sv]
// package: register map, field widths, reset values and carrier types for the trim/debug bank
package atd_pkg;
    localparam logic [7:0] Z_OFFSET_TRIM_ADDR = 8'h22;
    localparam logic [7:0] X_CONST_SHIFT_ADDR = 8'h24;
    localparam logic [7:0] Y_CONST_SHIFT_ADDR = 8'h25;
    localparam logic [7:0] Z_CONST_SHIFT_ADDR = 8'h26;
    localparam logic [7:0] X_STEP_STIMULUS_ADDR = 8'h28;
    localparam logic [7:0] Y_STEP_STIMULUS_ADDR = 8'h29;
    localparam logic [7:0] Z_STEP_STIMULUS_ADDR = 8'h2a;
    localparam logic [7:0] BAND_COEF_ONE_ADDR = 8'h2c;
    localparam logic [7:0] BAND_COEF_TWO_ADDR = 8'h2d;
    localparam logic [7:0] BAND_COEF_THREE_ADDR = 8'h2e;
    localparam logic [7:0] BAND_COEF_FOUR_ADDR = 8'h2f;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam logic [11:0] SAMPLE_RESET_VALUE = 12'h000;
    localparam logic [13:0] VECTOR_RESET_VALUE = 14'h0000;
    localparam int TRIM_SCALE_SHIFT = 1;       // trim is doubled before subtraction
    localparam int STIM_SAMPLE_SHIFT = 4;      // 8-bit stimulus lands in top of 12-bit sample

    // one three-axis signed sample
    typedef struct packed {
        logic signed [11:0] x;
        logic signed [11:0] y;
        logic signed [11:0] z;
    } atd_axes_type;

    // register-port request from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } atd_reg_req_type;

    // four band-pass coefficients
    typedef struct packed {
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
        logic [7:0] c4;
    } atd_coef_type;
endpackage

// [logic/atd_vector_filter.sv]
// vector length approximation and coefficient-tuned band-pass stage
`timescale 1ns/10ps
module atd_vector_filter
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic sample_in,                 // one-cycle strobe: new sample present
    input wire atd_pkg::atd_axes_type axes_in,
    input wire atd_pkg::atd_coef_type coef_in,
    input wire logic enable_in,                 // vector_filter_enable
    output logic [13:0] length_out,
    output logic [13:0] filtered_out
);
    ////////////////////////////////////////////////////////////////////////////
    logic [11:0] ax, ay, az;                    // absolute axis values
    logic [11:0] big, mid, sml;                 // sorted magnitudes
    logic [13:0] len_nxt;
    logic signed [17:0] hp_r, hp_nxt;           // high-pass state
    logic signed [17:0] lp_r, lp_nxt;           // low-pass state
    logic [13:0] len_r, filt_r, filt_nxt;

    // magnitude approx: max + mid/2 + min/4 (no square root)
    always_comb
    begin
        ax = axes_in.x[11] ? 12'(-axes_in.x) : 12'(axes_in.x);
        ay = axes_in.y[11] ? 12'(-axes_in.y) : 12'(axes_in.y);
        az = axes_in.z[11] ? 12'(-axes_in.z) : 12'(axes_in.z);
        big = ax;
        mid = ay;
        sml = az;
        if (ay > ax)
        begin
            big = ay;
            mid = ax;
        end
        if (az > big)
        begin
            sml = mid;
            mid = big;
            big = az;
        end
        else if (az > mid)
        begin
            sml = mid;
            mid = az;
        end
        len_nxt = 14'(big) + 14'(mid >> 1) + 14'(sml >> 2);
    end

    // band-pass: first-order high-pass then low-pass, gains in 1/256 steps
    always_comb
    begin
        hp_nxt = hp_r;
        lp_nxt = lp_r;
        filt_nxt = filt_r;
        if (!enable_in)
        begin
            // bypass: length passes unfiltered, state is cleared
            hp_nxt = 18'sh00000;
            lp_nxt = 18'sh00000;
            filt_nxt = len_nxt;
        end
        else if (sample_in)
        begin
            // tracker follows the slow part; c1 rate, c2 gain on the residue
            hp_nxt = 18'(hp_r + ((($signed({4'h0, len_nxt}) - hp_r)
                     * $signed({1'b0, coef_in.c1})) >>> 8));
            lp_nxt = 18'(lp_r + (((((($signed({4'h0, len_nxt}) - hp_r)
                     * $signed({1'b0, coef_in.c2})) >>> 8) - lp_r)
                     * $signed({1'b0, coef_in.c3})) >>> 8));
            // c4 scales output; negative low-pass state clamps to zero
            filt_nxt = lp_nxt[17] ? 14'h0000
                       : 14'((lp_nxt * $signed({1'b0, coef_in.c4})) >>> 8);
        end
    end

    // state registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            hp_r <= 18'sh00000;
            lp_r <= 18'sh00000;
            len_r <= atd_pkg::VECTOR_RESET_VALUE;
            filt_r <= atd_pkg::VECTOR_RESET_VALUE;
        end
        else if (ce_in)
        begin
            hp_r <= hp_nxt;
            lp_r <= lp_nxt;
            filt_r <= filt_nxt;
            if (sample_in)
            begin
                len_r <= len_nxt;
            end
        end
    end

    assign length_out = len_r;
    assign filtered_out = filt_r;
endmodule

// [logic/atd_regs.sv]
// axis trim, constant shift, step stimulus and vector coefficient register bank
`timescale 1ns/10ps

module atd_regs
(
    input wire logic clk_in,
    input wire logic rst_b_in,                  // synchronous, also soft reset
    input wire logic ce_in,                     // freezes all state when low
    input wire atd_pkg::atd_reg_req_type req_in,// register port, same clock
    input wire logic step_debug_in,             // step-debug mode bit
    input wire logic vector_filter_enable_in,   // vector_filter_enable
    input wire logic program_output_read_in,    // read of program_output_register
    input wire logic sample_valid_in,           // live sample strobe
    input wire atd_pkg::atd_axes_type x_off_in, // x/y trims in the .x/.y low bytes
    input wire atd_pkg::atd_axes_type raw_in,   // raw live axes
    output logic [7:0] rdata_out,
    output logic rdata_hit_out,                 // address belongs to this bank
    output atd_pkg::atd_axes_type stream_out,   // trimmed stream data
    output logic stream_valid_out,
    output atd_pkg::atd_axes_type prog_one_out, // samples for program one
    output atd_pkg::atd_axes_type prog_two_shifted_difference_function_out, // program two difference inputs
    output logic prog_valid_out,                // program step strobe
    output logic [13:0] vector_length_out,
    output logic [13:0] vector_filtered_out
);
    ////////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] z_offset_trim_r, z_offset_trim_nxt;
    atd_pkg::atd_axes_type shift_r, shift_nxt;  // 8-bit values in low byte
    logic [7:0] stim_x_r, stim_x_nxt;
    logic [7:0] stim_y_r, stim_y_nxt;
    logic [7:0] stim_z_r, stim_z_nxt;
    atd_pkg::atd_coef_type coef_r, coef_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic hit_r, hit_nxt;

    // register writes and read mux
    always_comb
    begin
        z_offset_trim_nxt = z_offset_trim_r;
        shift_nxt = shift_r;
        stim_x_nxt = stim_x_r;
        stim_y_nxt = stim_y_r;
        stim_z_nxt = stim_z_r;
        coef_nxt = coef_r;
        rdata_nxt = rdata_r;
        hit_nxt = 1'b0;
        if (req_in.wr)
        begin
            case (req_in.addr)
                atd_pkg::Z_OFFSET_TRIM_ADDR: z_offset_trim_nxt = req_in.wdata;
                atd_pkg::X_CONST_SHIFT_ADDR: shift_nxt.x = 12'(req_in.wdata);
                atd_pkg::Y_CONST_SHIFT_ADDR: shift_nxt.y = 12'(req_in.wdata);
                atd_pkg::Z_CONST_SHIFT_ADDR: shift_nxt.z = 12'(req_in.wdata);
                atd_pkg::X_STEP_STIMULUS_ADDR: stim_x_nxt = req_in.wdata;
                atd_pkg::Y_STEP_STIMULUS_ADDR: stim_y_nxt = req_in.wdata;
                atd_pkg::Z_STEP_STIMULUS_ADDR: stim_z_nxt = req_in.wdata;
                atd_pkg::BAND_COEF_ONE_ADDR: coef_nxt.c1 = req_in.wdata;
                atd_pkg::BAND_COEF_TWO_ADDR: coef_nxt.c2 = req_in.wdata;
                atd_pkg::BAND_COEF_THREE_ADDR: coef_nxt.c3 = req_in.wdata;
                atd_pkg::BAND_COEF_FOUR_ADDR: coef_nxt.c4 = req_in.wdata;
                default: ; // other addresses belong elsewhere
            endcase
        end
        if (req_in.rd)
        begin
            hit_nxt = 1'b1;
            case (req_in.addr)
                atd_pkg::Z_OFFSET_TRIM_ADDR: rdata_nxt = z_offset_trim_r;
                atd_pkg::X_CONST_SHIFT_ADDR: rdata_nxt = shift_r.x[7:0];
                atd_pkg::Y_CONST_SHIFT_ADDR: rdata_nxt = shift_r.y[7:0];
                atd_pkg::Z_CONST_SHIFT_ADDR: rdata_nxt = shift_r.z[7:0];
                atd_pkg::X_STEP_STIMULUS_ADDR: rdata_nxt = stim_x_r;
                atd_pkg::Y_STEP_STIMULUS_ADDR: rdata_nxt = stim_y_r;
                atd_pkg::Z_STEP_STIMULUS_ADDR: rdata_nxt = stim_z_r;
                atd_pkg::BAND_COEF_ONE_ADDR: rdata_nxt = coef_r.c1;
                atd_pkg::BAND_COEF_TWO_ADDR: rdata_nxt = coef_r.c2;
                atd_pkg::BAND_COEF_THREE_ADDR: rdata_nxt = coef_r.c3;
                atd_pkg::BAND_COEF_FOUR_ADDR: rdata_nxt = coef_r.c4;
                default:
                begin
                    // not ours: answer zero and drop the hit flag
                    rdata_nxt = 8'h00;
                    hit_nxt = 1'b0;
                end
            endcase
        end
    end

    // register bank flops; reset clears every register
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            z_offset_trim_r <= atd_pkg::REG_RESET_VALUE;
            shift_r <= '0;
            stim_x_r <= atd_pkg::REG_RESET_VALUE;
            stim_y_r <= atd_pkg::REG_RESET_VALUE;
            stim_z_r <= atd_pkg::REG_RESET_VALUE;
            coef_r <= '0;
            rdata_r <= atd_pkg::REG_RESET_VALUE;
            hit_r <= 1'b0;
        end
        else if (ce_in)
        begin
            z_offset_trim_r <= z_offset_trim_nxt;
            shift_r <= shift_nxt;
            stim_x_r <= stim_x_nxt;
            stim_y_r <= stim_y_nxt;
            stim_z_r <= stim_z_nxt;
            coef_r <= coef_nxt;
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // signal path: trim, source select, shift
    atd_pkg::atd_axes_type stream_r, stream_nxt;
    atd_pkg::atd_axes_type prog_r, prog_nxt;
    atd_pkg::atd_axes_type shifted_difference_function_r, shifted_difference_function_nxt;
    logic stream_valid_r, stream_valid_nxt;
    logic prog_valid_r, prog_valid_nxt;
    logic step_now;                             // live sample, or program output read in step-debug mode, drives programs this cycle
    atd_pkg::atd_axes_type trimmed;
    atd_pkg::atd_axes_type src;

    // registers are sampled here, so a write lands on the next sample
    always_comb
    begin
        // x/y trims come in on x_off_in.x/.y low bytes
        trimmed.x = 12'(raw_in.x - (12'($signed(x_off_in.x[7:0])) <<< atd_pkg::TRIM_SCALE_SHIFT));
        trimmed.y = 12'(raw_in.y - (12'($signed(x_off_in.y[7:0])) <<< atd_pkg::TRIM_SCALE_SHIFT));
        trimmed.z = 12'(raw_in.z
                    - (12'($signed(z_offset_trim_r)) <<< atd_pkg::TRIM_SCALE_SHIFT));
        stream_nxt = stream_r;
        stream_valid_nxt = sample_valid_in;
        if (sample_valid_in)
        begin
            stream_nxt = trimmed;
        end
        if (step_debug_in)
        begin
            // stimulus bytes scaled to sample width
            src.x = 12'($signed(stim_x_r)) <<< atd_pkg::STIM_SAMPLE_SHIFT;
            src.y = 12'($signed(stim_y_r)) <<< atd_pkg::STIM_SAMPLE_SHIFT;
            src.z = 12'($signed(stim_z_r)) <<< atd_pkg::STIM_SAMPLE_SHIFT;
            step_now = program_output_read_in;
        end
        else
        begin
            src = trimmed;
            step_now = sample_valid_in;
        end
        prog_nxt = prog_r;
        shifted_difference_function_nxt = shifted_difference_function_r;
        prog_valid_nxt = step_now;
        if (step_now)
        begin
            prog_nxt = src;
            // constant shift only on the program-two difference path
            shifted_difference_function_nxt.x = 12'(src.x - $signed(12'($signed(shift_r.x[7:0]))));
            shifted_difference_function_nxt.y = 12'(src.y - $signed(12'($signed(shift_r.y[7:0]))));
            shifted_difference_function_nxt.z = 12'(src.z - $signed(12'($signed(shift_r.z[7:0]))));
        end
    end

    // path flops
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            stream_r <= '0;
            prog_r <= '0;
            shifted_difference_function_r <= '0;
            stream_valid_r <= 1'b0;
            prog_valid_r <= 1'b0;
        end
        else if (ce_in)
        begin
            stream_r <= stream_nxt;
            prog_r <= prog_nxt;
            shifted_difference_function_r <= shifted_difference_function_nxt;
            stream_valid_r <= stream_valid_nxt;
            prog_valid_r <= prog_valid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // vector length and band-pass on the program input
    atd_vector_filter u_vector_filter_enable
    (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .sample_in(prog_valid_r),
        .axes_in(prog_r),
        .coef_in(coef_r),
        .enable_in(vector_filter_enable_in),
        .length_out(vector_length_out),
        .filtered_out(vector_filtered_out)
    );

    assign rdata_out = rdata_r;
    assign rdata_hit_out = hit_r;
    assign stream_out = stream_r;
    assign stream_valid_out = stream_valid_r;
    assign prog_one_out = prog_r;
    assign prog_two_shifted_difference_function_out = shifted_difference_function_r;
    assign prog_valid_out = prog_valid_r;
endmodule

// [sim/atd_regs_properties.sv]
// checker: port-level properties of the trim/debug register bank
`timescale 1ns/10ps
module atd_regs_checker
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire atd_pkg::atd_reg_req_type req_in,
    input wire logic step_debug_in,
    input wire logic vector_filter_enable_in,
    input wire logic program_output_read_in,
    input wire logic sample_valid_in,
    input wire logic [7:0] rdata_out,
    input wire logic rdata_hit_out,
    input wire logic stream_valid_out,
    input wire atd_pkg::atd_axes_type prog_one_out,
    input wire atd_pkg::atd_axes_type prog_two_shifted_difference_function_out,
    input wire logic prog_valid_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic mapped; // address decodes into this bank
    logic [7:0] sx_r; // shadow of x constant shift
    logic [7:0] sx_nxt;
    ////////////////////////////////////////////////////////////////////////////////
    // decode and shadow next value
    always_comb
    begin
        mapped = req_in.addr inside {8'h22, [8'h24:8'h26], [8'h28:8'h2a], [8'h2c:8'h2f]};
        sx_nxt = sx_r;
        if (!rst_b_in)
            sx_nxt = 8'h00;
        else if (ce_in && req_in.wr && req_in.addr == atd_pkg::X_CONST_SHIFT_ADDR)
            sx_nxt = req_in.wdata;
    end
    // shadow register only
    always_ff @(posedge clk_in)
    begin
        sx_r <= sx_nxt;
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_read_hit;
        ce_in && req_in.rd && mapped |=> rdata_hit_out;
    endproperty
    a_read_hit: assert property (p_read_hit) else $error("mapped read without hit");
    property p_unmapped;
        ce_in && req_in.rd && !mapped |=> !rdata_hit_out && rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_hit_cause;
        $past(ce_in) && rdata_hit_out |-> $past(req_in.rd && mapped);
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without read");
    property p_live_step;
        ce_in && sample_valid_in && !step_debug_in |=> prog_valid_out && stream_valid_out;
    endproperty
    a_live_step: assert property (p_live_step) else $error("live sample not fed");
    property p_debug_hold;
        ce_in && step_debug_in && !program_output_read_in |=> !prog_valid_out;
    endproperty
    a_debug_hold: assert property (p_debug_hold) else $error("debug step w/o read");
    property p_debug_step;
        ce_in && step_debug_in && program_output_read_in |=> prog_valid_out;
    endproperty
    a_debug_step: assert property (p_debug_step) else $error("read did not step");
    property p_shifted_difference_function;
        prog_valid_out |-> prog_two_shifted_difference_function_out.x == prog_one_out.x - {{4{sx_r[7]}}, sx_r};
    endproperty
    a_shifted_difference_function: assert property (p_shifted_difference_function) else $error("difference shift wrong");
    property p_stream_cause;
        $past(ce_in) && stream_valid_out |-> $past(sample_valid_in);
    endproperty
    a_stream_cause: assert property (p_stream_cause) else $error("stray stream pulse");
    // enable low must hold read data, hit flag and program-one sample, request or not
    property p_freeze;
        !ce_in |=> $stable(rdata_out) && $stable(rdata_hit_out) && $stable(prog_one_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");
endmodule
bind atd_regs atd_regs_checker i_atd_regs_checker (.clk_in, .rst_b_in, .ce_in, .req_in,
    .step_debug_in, .vector_filter_enable_in, .program_output_read_in, .sample_valid_in,
    .rdata_out, .rdata_hit_out, .stream_valid_out, .prog_one_out, .prog_two_shifted_difference_function_out,
    .prog_valid_out);

// [sim/atd_host_model.sv]
// host model: register writes, reads and debug steps off the falling edge
`timescale 1ns/10ps
module atd_host_model
(
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic hit_in,
    output atd_pkg::atd_reg_req_type req_out,
    output logic prog_read_out
);
    // idle request port from time zero
    initial
    begin
        req_out = 18'h00000;
        prog_read_out = 1'b0;
    end
    // one-cycle write pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        req_out = {1'b1, 1'b0, a, d};
        @(negedge clk_in);
        req_out = 18'h00000;
    endtask
    // read: answer stands in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge clk_in);
        req_out = {1'b0, 1'b1, a, 8'h00};
        @(negedge clk_in);
        d = rdata_in;
        h = hit_in;
        req_out = 18'h00000;
    endtask
    // read of the program output register, a step in debug mode
    task automatic step();
        @(negedge clk_in);
        prog_read_out = 1'b1;
        @(negedge clk_in);
        prog_read_out = 1'b0;
    endtask
endmodule

// [sim/test_axis_trim_debug_vector_regs.sv]
// testbench: register map, trim, shift, debug step and vector path
`timescale 1ns/10ps
module test_axis_trim_debug_vector_regs;
    logic clk_in, rst_b_in, ce_in, step_debug_in, vfe_in, por_in, sv_in, hit;
    logic [7:0] rdata, d;
    logic h;
    atd_pkg::atd_reg_req_type req;
    atd_pkg::atd_axes_type xoff, raw, so, p1, p2;
    logic so_v, p_v;
    logic [13:0] len, filt;
    int bad_count, check_count;
    logic [7:0] regs [11] = '{8'h22, 8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h2a, 8'h2c,
        8'h2d, 8'h2e, 8'h2f};
    atd_regs i_atd_regs (.clk_in, .rst_b_in, .ce_in, .req_in(req), .step_debug_in,
        .vector_filter_enable_in(vfe_in), .program_output_read_in(por_in),
        .sample_valid_in(sv_in), .x_off_in(xoff), .raw_in(raw), .rdata_out(rdata),
        .rdata_hit_out(hit), .stream_out(so), .stream_valid_out(so_v), .prog_one_out(p1),
        .prog_two_shifted_difference_function_out(p2), .prog_valid_out(p_v), .vector_length_out(len),
        .vector_filtered_out(filt));
    atd_host_model i_atd_host_model (.clk_in, .rdata_in(rdata), .hit_in(hit),
        .req_out(req), .prog_read_out(por_in));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    // one compare kind: zero-extended values
    task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // register read with data and hit judged
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic eh);
        i_atd_host_model.rd(a, d, h);
        chk("rdata", 14'(e), 14'(d));
        chk("hit", 14'(eh), 14'(h));
    endtask
    // one live sample pulse; outputs settled on return
    task automatic samp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(negedge clk_in);
        raw = {x, y, z};
        sv_in = 1'b1;
        @(negedge clk_in);
        sv_in = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_map();
        // write with enable low must be lost; first read below still sees zero
        ce_in = 1'b0;
        i_atd_host_model.wr(atd_pkg::Z_OFFSET_TRIM_ADDR, 8'h55);
        ce_in = 1'b1;
        foreach (regs[i]) rchk(regs[i], 8'h00, 1'b1);
        foreach (regs[i]) i_atd_host_model.wr(regs[i], 8'ha0 ^ 8'(i));
        foreach (regs[i]) rchk(regs[i], 8'ha0 ^ 8'(i), 1'b1);
        rchk(8'h23, 8'h00, 1'b0);
        rchk(8'h2b, 8'h00, 1'b0);
        foreach (regs[i]) i_atd_host_model.wr(regs[i], 8'h00);
    endtask
    // negative z trim doubled, x trim from the neighbour bank
    task automatic t_trim();
        i_atd_host_model.wr(atd_pkg::Z_OFFSET_TRIM_ADDR, 8'hfd);
        samp(12'h010, 12'h020, 12'h064);
        chk("stream z", 14'h006a, 14'(so.z));
        chk("stream x", 14'h000c, 14'(so.x));
        i_atd_host_model.wr(atd_pkg::Z_OFFSET_TRIM_ADDR, 8'h00);
    endtask
    // shifts reach only the difference outputs
    task automatic t_shift();
        i_atd_host_model.wr(atd_pkg::X_CONST_SHIFT_ADDR, 8'hfb);
        i_atd_host_model.wr(atd_pkg::Y_CONST_SHIFT_ADDR, 8'h05);
        samp(12'h028, 12'h030, 12'h000);
        chk("prog valid", 14'h0001, 14'(p_v));
        chk("prog x", 14'h0024, 14'(p1.x));
        chk("stream y", 14'h0030, 14'(so.y));
        chk("shifted_difference_function x", 14'h0029, 14'(p2.x));
        chk("shifted_difference_function y", 14'h002b, 14'(p2.y));
    endtask
    // stepping with stimulus bytes, then vector length and filter
    task automatic t_debug();
        xoff = 36'h000000000;
        step_debug_in = 1'b1;
        i_atd_host_model.wr(atd_pkg::X_STEP_STIMULUS_ADDR, 8'h04);
        i_atd_host_model.wr(atd_pkg::Y_STEP_STIMULUS_ADDR, 8'h02);
        i_atd_host_model.wr(atd_pkg::Z_STEP_STIMULUS_ADDR, 8'h01);
        samp(12'h100, 12'h100, 12'h100);
        chk("live blocked", 14'h0000, 14'(p_v));
        chk("stream on", 14'h0001, 14'(so_v));
        i_atd_host_model.step();
        chk("step valid", 14'h0001, 14'(p_v));
        chk("stim", 14'h0040, 14'(p1.x));
        chk("stim z", 14'h0010, 14'(p1.z));
        @(negedge clk_in);
        chk("length", 14'h0054, len);
        chk("bypass", 14'h0054, filt);
        vfe_in = 1'b1;
        i_atd_host_model.step();
        @(negedge clk_in);
        chk("zero coef", 14'h0000, filt);
        // 0x54 * 0x80/256 = 0x2a, * 0x80/256 = 0x15, * 0xff/256 = 0x14
        i_atd_host_model.wr(atd_pkg::BAND_COEF_TWO_ADDR, 8'h80);
        i_atd_host_model.wr(atd_pkg::BAND_COEF_THREE_ADDR, 8'h80);
        i_atd_host_model.wr(atd_pkg::BAND_COEF_FOUR_ADDR, 8'hff);
        i_atd_host_model.step();
        @(negedge clk_in);
        chk("tuned", 14'h0014, filt);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog well past the expected 141 or so cycles
    initial
    begin
        #1000000;
        bad_count++;
        conclude();
    end
    initial
    begin
        rst_b_in = 1'b0;
        ce_in = 1'b1;
        {step_debug_in, vfe_in, sv_in} = 3'h0;
        xoff = {12'h002, 24'h000000};
        raw = 36'h000000000;
        repeat (12) @(negedge clk_in);
        rst_b_in = 1'b1;
        t_map();
        t_trim();
        t_shift();
        t_debug();
        conclude();
    end
endmodule
